// *** rtl/iec_cfg.svh ***
// constants of the interrupt and event transfer block
`ifndef IEC_CFG_SVH
`define IEC_CFG_SVH
`define IEC_NODES        48
`define IEC_NODE_W       6
`define IEC_LVL_W        4
`define IEC_CHANS        8
`define IEC_CH_W         3
`define IEC_EXT          4
`define IEC_EXT_NODE0    6'h2C
`define IEC_TRAP_W       7
`define IEC_TRAP_BASE    7'h10
`define IEC_VEC_W        9
`define IEC_VEC_SHIFT    2
`define IEC_ADDR_W       24
`define IEC_CNT_W        8
`define IEC_RESP_JC      4'h7
`define IEC_RESP_NOJC    4'hB
`define IEC_ARB_LAT      4'h2
`define IEC_EDGE_OFF     2'h0
`define IEC_EDGE_RISE    2'h1
`define IEC_EDGE_FALL    2'h2
`define IEC_EDGE_BOTH    2'h3
`define IEC_WORD_INC     24'h000002
`define IEC_BYTE_INC     24'h000001
`define IEC_RST_ZERO     1'b0
`endif

// *** rtl/iec_pkg.sv ***
// types of the interrupt and event transfer block
`include "iec_cfg.svh"
package iec_pkg;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_OFFER  = 5'h02,
		ST_BRANCH = 5'h04,
		ST_FETCH  = 5'h08,
		ST_MOVE   = 5'h10
	} iec_state_e;

	typedef struct packed {
		logic [`IEC_ADDR_W-1:0] src;
		logic [`IEC_ADDR_W-1:0] dst;
		logic [`IEC_CNT_W-1:0]  cnt;
		logic                   inc_src;
		logic                   inc_dst;
		logic                   word;
		logic                   cont;
	} iec_chan_s;

	typedef struct packed {
		iec_state_e                              st;
		logic [`IEC_NODES-1:0]                   ir;
		logic [`IEC_NODES-1:0]                   ie;
		logic [`IEC_NODES-1:0]                   event_transfer_engine;
		logic [`IEC_NODES-1:0][`IEC_LVL_W-1:0]   lvl;
		logic [`IEC_NODES-1:0][`IEC_CH_W-1:0]    ch;
		logic [`IEC_NODE_W-1:0]                  win;
		logic                                    win_trap;
		logic [3:0]                              cnt;
		logic                                    irq;
		logic [`IEC_VEC_W-1:0]                   vec;
		logic [`IEC_LVL_W-1:0]                   ilvl;
		logic                                    trap;
		logic                                    branch;
		logic                                    xreq;
		logic [`IEC_ADDR_W-1:0]                  xsrc;
		logic [`IEC_ADDR_W-1:0]                  xdst;
		logic                                    xword;
		logic                                    busy;
	} iec_core_s;
endpackage

// *** rtl/iec_edge_det.sv ***
// fast external input synchroniser with selectable edge detection
`include "iec_cfg.svh"
module iec_edge_det (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       pin_i,
	input  wire logic [1:0] mode_i,
	output logic            evt_o
);
	typedef struct packed {
		logic [2:0] sync;
		logic       stable;
		logic       evt;
	} iec_edge_s;

	iec_edge_s q;
	iec_edge_s d;

	always_comb begin
		d      = q;
		d.sync = {q.sync[1:0], pin_i};
		d.evt  = 1'b0;
		// first stage feeds only the second; stages two and three vote
		if (q.sync[1] == q.sync[2] && q.sync[2] != q.stable) begin
			d.stable = q.sync[2];
			unique case (mode_i)
				`IEC_EDGE_RISE: d.evt = q.sync[2];
				`IEC_EDGE_FALL: d.evt = ~q.sync[2];
				`IEC_EDGE_BOTH: d.evt = 1'b1;
				default:        d.evt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign evt_o = q.evt;
endmodule

// *** rtl/iec_chan_mem.sv ***
// per-channel pointer, counter and mode store with registered read
`include "iec_cfg.svh"
module iec_chan_mem (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   ce_i,
	input  wire logic                   we_i,
	input  wire logic [`IEC_CH_W-1:0]   waddr_i,
	input  wire iec_pkg::iec_chan_s     wdata_i,
	input  wire logic [`IEC_CH_W-1:0]   raddr_i,
	output iec_pkg::iec_chan_s          rdata_o
);
	typedef struct packed {
		iec_pkg::iec_chan_s [`IEC_CHANS-1:0] mem;
		iec_pkg::iec_chan_s                  rd;
	} iec_mem_s;

	iec_mem_s q;
	iec_mem_s d;

	always_comb begin
		d    = q;
		d.rd = q.mem[raddr_i];
		if (we_i) begin
			d.mem[waddr_i] = wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign rdata_o = q.rd;
endmodule

// *** rtl/iec_top.sv ***
// prioritised interrupt controller with event transfer channels
`include "iec_cfg.svh"
module iec_top (
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          ce_i,
	input  wire logic [`IEC_NODES-1:0]         periph_req_i,
	input  wire logic [`IEC_EXT-1:0]           ext_pin_i,
	input  wire logic [2*`IEC_EXT-1:0]         ext_edge_i,
	input  wire logic                          node_we_i,
	input  wire logic [`IEC_NODE_W-1:0]        node_idx_i,
	input  wire logic                          node_ir_i,
	input  wire logic                          node_ie_i,
	input  wire logic [`IEC_LVL_W-1:0]         node_lvl_i,
	input  wire logic                          node_pec_i,
	input  wire logic [`IEC_CH_W-1:0]          node_ch_i,
	input  wire logic                          chan_we_i,
	input  wire logic [`IEC_CH_W-1:0]          chan_idx_i,
	input  wire logic [`IEC_ADDR_W-1:0]        chan_src_i,
	input  wire logic [`IEC_ADDR_W-1:0]        chan_dst_i,
	input  wire logic [`IEC_CNT_W-1:0]         chan_cnt_i,
	input  wire logic                          chan_inc_src_i,
	input  wire logic                          chan_inc_dst_i,
	input  wire logic                          chan_word_i,
	input  wire logic                          chan_cont_i,
	input  wire logic                          trap_req_i,
	input  wire logic [`IEC_TRAP_W-1:0]        trap_num_i,
	input  wire logic [`IEC_LVL_W-1:0]         cpu_level_i,
	input  wire logic                          jump_cache_i,
	input  wire logic                          irq_ack_i,
	output logic                               irq_o,
	output logic [`IEC_VEC_W-1:0]              irq_vec_o,
	output logic [`IEC_LVL_W-1:0]              irq_lvl_o,
	output logic                               irq_trap_o,
	output logic                               branch_o,
	output logic                               xfer_req_o,
	output logic [`IEC_ADDR_W-1:0]             xfer_src_o,
	output logic [`IEC_ADDR_W-1:0]             xfer_dst_o,
	output logic                               xfer_word_o,
	output logic [`IEC_NODES-1:0]              node_ir_o,
	output logic                               busy_o
);
	iec_pkg::iec_core_s q;
	iec_pkg::iec_core_s d;

	logic [`IEC_EXT-1:0]      ext_evt;
	logic [`IEC_NODES-1:0]    hw_set;
	logic [`IEC_NODES-1:0]    pend;
	iec_pkg::iec_chan_s       ch_rd;
	iec_pkg::iec_chan_s       ch_wr;
	logic                     ch_we;
	logic [`IEC_CH_W-1:0]     ch_waddr;
	logic [`IEC_CH_W-1:0]     ch_raddr;
	logic                     arb_found;
	logic [`IEC_NODE_W-1:0]   arb_node;
	logic [`IEC_LVL_W-1:0]    arb_lvl;
	logic [`IEC_CNT_W-1:0]    cnt_next;

	// trap number to vector offset, shared by nodes and traps
	function automatic logic [`IEC_VEC_W-1:0] vec_off(
		input logic [`IEC_TRAP_W-1:0] num
	);
		vec_off = {num, 2'b00};
	endfunction

	// node index to its trap number
	function automatic logic [`IEC_TRAP_W-1:0] node_trap(
		input logic [`IEC_NODE_W-1:0] idx
	);
		node_trap = `IEC_TRAP_BASE + {1'b0, idx};
	endfunction

	// pointer bump of one transfer unit
	function automatic logic [`IEC_ADDR_W-1:0] ptr_step(
		input logic is_word
	);
		ptr_step = is_word ? `IEC_WORD_INC : `IEC_BYTE_INC;
	endfunction

	// countdown after the ack; arbitration has already spent two cycles
	function automatic logic [3:0] resp_load(
		input logic jc
	);
		resp_load = (jc ? `IEC_RESP_JC : `IEC_RESP_NOJC) - `IEC_ARB_LAT;
	endfunction

	// channel with nothing left to move outside continuous mode
	function automatic logic chan_done(
		input iec_pkg::iec_chan_s c
	);
		chan_done = (c.cnt == '0) && !c.cont;
	endfunction

	genvar g;
	generate
		for (g = 0; g < `IEC_EXT; g++) begin : g_ext
			iec_edge_det u_edge (
				.clk_sys_i (clk_sys_i),
				.rst_n_i   (rst_n_i),
				.ce_i      (ce_i),
				.pin_i     (ext_pin_i[g]),
				.mode_i    (ext_edge_i[2*g+1:2*g]),
				.evt_o     (ext_evt[g])
			);
		end
	endgenerate

	iec_chan_mem u_chan (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.we_i      (ch_we),
		.waddr_i   (ch_waddr),
		.wdata_i   (ch_wr),
		.raddr_i   (ch_raddr),
		.rdata_o   (ch_rd)
	);

	// external events land on the top nodes of the table
	always_comb begin
		hw_set = periph_req_i;
		for (int i = 0; i < `IEC_EXT; i++) begin
			hw_set[`IEC_EXT_NODE0 + i] = hw_set[`IEC_EXT_NODE0 + i]
				| ext_evt[i];
		end
	end

	// a disabled node keeps its flag but stays out of arbitration
	assign pend = q.ir & q.ie;

	// strict compare keeps ties on the lowest index
	always_comb begin
		arb_found = 1'b0;
		arb_node  = '0;
		arb_lvl   = cpu_level_i;
		for (int i = 0; i < `IEC_NODES; i++) begin
			if (pend[i] && q.lvl[i] > arb_lvl) begin
				arb_found = 1'b1;
				arb_node  = i[`IEC_NODE_W-1:0];
				arb_lvl   = q.lvl[i];
			end
		end
	end

	assign cnt_next = ch_rd.cnt - `IEC_CNT_W'(1);

	always_comb begin
		d        = q;
		d.branch = 1'b0;
		d.xreq   = 1'b0;
		ch_we    = 1'b0;
		ch_waddr = chan_idx_i;
		ch_raddr = q.ch[arb_node];
		ch_wr.src     = chan_src_i;
		ch_wr.dst     = chan_dst_i;
		ch_wr.cnt     = chan_cnt_i;
		ch_wr.inc_src = chan_inc_src_i;
		ch_wr.inc_dst = chan_inc_dst_i;
		ch_wr.word    = chan_word_i;
		ch_wr.cont    = chan_cont_i;

		if (node_we_i) begin
			d.ir[node_idx_i]  = node_ir_i;
			d.ie[node_idx_i]  = node_ie_i;
			d.lvl[node_idx_i] = node_lvl_i;
			d.event_transfer_engine[node_idx_i] = node_pec_i;
			d.ch[node_idx_i]  = node_ch_i;
		end

		unique case (q.st)
			iec_pkg::ST_IDLE: begin
				// host channel writes only land while the controller is idle
				ch_we = chan_we_i;
				// a trap outranks every node; one that comes while busy is lost
				if (trap_req_i) begin
					d.st       = iec_pkg::ST_OFFER;
					d.irq      = 1'b1;
					d.trap     = 1'b1;
					d.win_trap = 1'b1;
					d.vec      = vec_off(trap_num_i);
					d.ilvl     = cpu_level_i;
				end else if (arb_found) begin
					d.win      = arb_node;
					d.win_trap = 1'b0;
					if (q.event_transfer_engine[arb_node]) begin
						d.st = iec_pkg::ST_FETCH;
					end else begin
						d.st   = iec_pkg::ST_OFFER;
						d.irq  = 1'b1;
						d.trap = 1'b0;
						d.vec  = vec_off(node_trap(arb_node));
						d.ilvl = arb_lvl;
					end
				end
			end

			iec_pkg::ST_OFFER: begin
				// no preemption while the offer waits for the core
				if (irq_ack_i) begin
					d.irq = 1'b0;
					if (!q.win_trap) begin
						d.ir[q.win] = 1'b0;
					end
					d.st  = iec_pkg::ST_BRANCH;
					d.cnt = resp_load(jump_cache_i);
				end
			end

			iec_pkg::ST_BRANCH: begin
				d.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h1) begin
					d.branch = 1'b1;
					d.st     = iec_pkg::ST_IDLE;
				end
			end

			iec_pkg::ST_FETCH: begin
				// an exhausted channel hands the node back as an interrupt
				if (chan_done(ch_rd)) begin
					d.event_transfer_engine[q.win] = 1'b0;
					d.st         = iec_pkg::ST_IDLE;
				end else begin
					d.xreq  = 1'b1;
					d.xsrc  = ch_rd.src;
					d.xdst  = ch_rd.dst;
					d.xword = ch_rd.word;
					d.ir[q.win] = 1'b0;
					ch_we    = 1'b1;
					ch_waddr = q.ch[q.win];
					ch_wr    = ch_rd;
					if (ch_rd.inc_src) begin
						ch_wr.src = ch_rd.src + ptr_step(ch_rd.word);
					end
					if (ch_rd.inc_dst) begin
						ch_wr.dst = ch_rd.dst + ptr_step(ch_rd.word);
					end
					if (!ch_rd.cont) begin
						ch_wr.cnt = cnt_next;
					end
					// count spent: the node turns into a standard interrupt
					if (chan_done(ch_wr)) begin
						d.event_transfer_engine[q.win] = 1'b0;
						d.ir[q.win]  = 1'b1;
					end
					d.st = iec_pkg::ST_MOVE;
				end
			end

			iec_pkg::ST_MOVE: begin
				d.st = iec_pkg::ST_IDLE;
			end

			default: begin
				d.st  = iec_pkg::ST_IDLE;
				d.irq = 1'b0;
			end
		endcase

		// hardware events win over any clear in the same cycle
		d.ir   = d.ir | hw_set;
		d.busy = (d.st != iec_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q    <= '0;
			q.st <= iec_pkg::ST_IDLE;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// every output is a plain register field
	assign irq_o       = q.irq;
	assign irq_vec_o   = q.vec;
	assign irq_lvl_o   = q.ilvl;
	assign irq_trap_o  = q.trap;
	assign branch_o    = q.branch;
	assign xfer_req_o  = q.xreq;
	assign xfer_src_o  = q.xsrc;
	assign xfer_dst_o  = q.xdst;
	assign xfer_word_o = q.xword;
	assign node_ir_o   = q.ir;
	assign busy_o      = q.busy;
endmodule

// *** dv/iec_top_monitor.sv ***
// assertions on the ports of the interrupt and event transfer block
module iec_top_monitor (
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic [47:0] periph_req_i,
	input wire logic        node_we_i,
	input wire logic [3:0]  cpu_level_i,
	input wire logic        jump_cache_i,
	input wire logic        irq_ack_i,
	input wire logic        irq_o,
	input wire logic [8:0]  irq_vec_o,
	input wire logic [3:0]  irq_lvl_o,
	input wire logic        irq_trap_o,
	input wire logic        branch_o,
	input wire logic        xfer_req_o,
	input wire logic [47:0] node_ir_o,
	input wire logic        busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_irq_holds: assert property (irq_o && !irq_ack_i |=> irq_o)
		else $error("offer dropped before ack");
	a_branch_fast: assert property (
		irq_o && irq_ack_i && jump_cache_i |-> ##6 branch_o)
		else $error("fast branch late");
	a_branch_slow: assert property (
		irq_o && irq_ack_i && !jump_cache_i |-> ##10 branch_o)
		else $error("slow branch late");
	a_xfer_single: assert property (
		xfer_req_o |=> !xfer_req_o && !busy_o)
		else $error("transfer longer than one cycle");
	a_xfer_quiet: assert property (xfer_req_o |-> !irq_o && !branch_o)
		else $error("transfer with vector");
	a_vec_slot: assert property (irq_o && !irq_trap_o |->
		irq_vec_o[1:0] == 2'h0 && irq_vec_o[8:2] inside {[7'h10:7'h3F]})
		else $error("vector off slot");
	a_level_above: assert property (
		$rose(irq_o) && !irq_trap_o |-> irq_lvl_o > $past(cpu_level_i))
		else $error("offer not above running level");
	a_ack_clears: assert property (irq_o && irq_ack_i && !irq_trap_o &&
		periph_req_i == 48'h0 && !node_we_i
		|=> node_ir_o[irq_vec_o[8:2] - 7'h10] == 1'b0)
		else $error("flag kept after ack");
	a_branch_ends: assert property (branch_o |-> !busy_o ##1 !branch_o)
		else $error("branch not a pulse");
	a_hw_sets: assert property (periph_req_i[3] |=> node_ir_o[3])
		else $error("request not latched");
	c_xfer: cover property (xfer_req_o);
	c_trap: cover property (branch_o && irq_trap_o);
	c_ack: cover property (irq_o && irq_ack_i);
endmodule

// *** dv/iec_core_model.sv ***
// core-side model that accepts offered interrupts
module iec_core_model (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic irq_i,
	input  wire logic slow_i,
	output logic      ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_q;
	// ack is one cycle; the offer falls on that edge
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !irq_i || ack_o) begin
			wait_q <= 2'h0;
			ack_o  <= 1'b0;
		end else if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
			ack_o <= 1'b1;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule

// *** dv/iec_top_tb.sv ***
// testbench of the interrupt and event transfer block
module iec_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i, rst_n_i, node_we_i, node_ir_i, node_ie_i;
	logic        node_pec_i, chan_we_i, chan_inc_src_i, chan_inc_dst_i;
	logic        chan_word_i, chan_cont_i, trap_req_i, jump_cache_i, slow;
	logic        irq_ack_i, irq_o, irq_trap_o, branch_o, xfer_req_o;
	logic        xfer_word_o, busy_o, ce;
	logic [47:0] periph_req_i, node_ir_o;
	logic [3:0]  ext_pin_i, node_lvl_i, cpu_level_i, irq_lvl_o;
	logic [7:0]  ext_edge_i, chan_cnt_i;
	logic [5:0]  node_idx_i;
	logic [2:0]  node_ch_i, chan_idx_i;
	logic [23:0] chan_src_i, chan_dst_i, xfer_src_o, xfer_dst_o;
	logic [6:0]  trap_num_i;
	logic [8:0]  irq_vec_o;
	int          n_errors, tests_run;

	iec_top iec_top_i (.clk_sys_i, .rst_n_i, .ce_i(ce), .periph_req_i,
		.ext_pin_i, .ext_edge_i, .node_we_i, .node_idx_i, .node_ir_i,
		.node_ie_i, .node_lvl_i, .node_pec_i, .node_ch_i, .chan_we_i,
		.chan_idx_i, .chan_src_i, .chan_dst_i, .chan_cnt_i, .chan_inc_src_i,
		.chan_inc_dst_i, .chan_word_i, .chan_cont_i, .trap_req_i, .trap_num_i,
		.cpu_level_i, .jump_cache_i, .irq_ack_i, .irq_o, .irq_vec_o,
		.irq_lvl_o, .irq_trap_o, .branch_o, .xfer_req_o, .xfer_src_o,
		.xfer_dst_o, .xfer_word_o, .node_ir_o, .busy_o);
	iec_core_model iec_core_model_i (.clk_sys_i, .rst_n_i, .irq_i(irq_o),
		.slow_i(slow), .ack_o(irq_ack_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task tick;
		@(posedge clk_sys_i);
		#1;
	endtask

	task print_verdict;
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [49:0] got, input logic [49:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task node(input int i, input logic ir, ie, input logic [3:0] lvl,
		input logic event_transfer_engine, input logic [2:0] ch);
		{node_idx_i, node_ir_i, node_ie_i} = {i[5:0], ir, ie};
		{node_lvl_i, node_pec_i, node_ch_i} = {lvl, event_transfer_engine, ch};
		node_we_i = 1'b1;
		tick;
		node_we_i = 1'b0;
		tick;
	endtask

	// mode bits: inc source, inc destination, word, continuous
	task chan(input logic [2:0] c, input logic [23:0] s, d,
		input logic [7:0] cnt, input logic [3:0] m);
		{chan_idx_i, chan_src_i, chan_dst_i, chan_cnt_i} = {c, s, d, cnt};
		{chan_inc_src_i, chan_inc_dst_i, chan_word_i, chan_cont_i} = m;
		chan_we_i = 1'b1;
		tick;
		chan_we_i = 1'b0;
	endtask

	task pulse(input int i);
		periph_req_i[i] = 1'b1;
		tick;
		periph_req_i = 48'h0;
	endtask

	// latency counts from the edge taking the ack: two less than response
	task serve(input logic [8:0] vec, input logic trap, input int lat);
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 40) begin
			tick;
			n++;
		end
		chk(irq_vec_o, vec);
		chk({irq_o, irq_trap_o}, {1'b1, trap});
		n = 0;
		while (irq_ack_i !== 1'b1 && n < 40) begin
			tick;
			n++;
		end
		tick;
		n = 0;
		while (branch_o !== 1'b1 && n < 40) begin
			tick;
			n++;
		end
		chk(n, lat - 2);
	endtask

	task xfer(input logic [23:0] s, d, input logic w);
		int n;
		n = 0;
		while (xfer_req_o !== 1'b1 && n < 20) begin
			tick;
			n++;
		end
		chk({xfer_req_o, xfer_word_o}, {1'b1, w});
		chk(xfer_src_o, s);
		chk(xfer_dst_o, d);
	endtask

	initial begin
		#200000;
		n_errors++;
		print_verdict;
	end

	initial begin
		{node_we_i, node_ir_i, node_ie_i, node_pec_i, chan_we_i} = '0;
		{chan_inc_src_i, chan_inc_dst_i, chan_word_i, chan_cont_i} = '0;
		{trap_req_i, slow, periph_req_i, ext_pin_i, ext_edge_i} = '0;
		{node_idx_i, node_lvl_i, node_ch_i, chan_idx_i, chan_cnt_i} = '0;
		{chan_src_i, chan_dst_i, trap_num_i, cpu_level_i} = '0;
		{rst_n_i, jump_cache_i, ce} = 3'b011;
		repeat (6) tick;
		rst_n_i = 1'b1;
		chk({irq_o, busy_o, node_ir_o}, 50'h0);
		// a write while the clock enable is low must not land
		ce = 1'b0;
		node(9, 1, 0, 4'h0, 0, 0);
		ce = 1'b1;
		tick;
		chk(node_ir_o[9], 1'b0);
		node(3, 0, 1, 4'h5, 0, 0);
		pulse(3);
		serve(9'h04C, 0, 7);
		{jump_cache_i, slow} = 2'b01;
		node(4, 1, 1, 4'h5, 0, 0);
		serve(9'h050, 0, 11);
		{jump_cache_i, slow} = 2'b10;
		node(10, 0, 1, 4'h3, 0, 0);
		node(20, 0, 1, 4'h9, 0, 0);
		periph_req_i = 48'h100400;
		tick;
		periph_req_i = 48'h0;
		serve(9'h090, 0, 7);
		chk(irq_lvl_o, 4'h9);
		serve(9'h068, 0, 7);
		cpu_level_i = 4'h4;
		node(5, 1, 1, 4'h4, 0, 0);
		repeat (10) tick;
		chk(irq_o, 0);
		cpu_level_i = 4'h3;
		serve(9'h054, 0, 7);
		cpu_level_i = 4'h0;
		node(30, 1, 0, 4'h7, 0, 0);
		repeat (10) tick;
		chk({irq_o, node_ir_o[30]}, 2'b01);
		node(30, 1, 1, 4'h7, 0, 0);
		serve(9'h0B8, 0, 7);
		for (int t = 16; t < 64; t += 27) begin
			trap_num_i = t[6:0];
			trap_req_i = 1'b1;
			tick;
			trap_req_i = 1'b0;
			serve({trap_num_i, 2'h0}, 1, 7);
		end
		chan(3'h2, 24'h000100, 24'h000200, 8'h02, 4'hE);
		node(7, 0, 1, 4'h6, 1, 3'h2);
		pulse(7);
		xfer(24'h000100, 24'h000200, 1);
		pulse(7);
		xfer(24'h000102, 24'h000202, 1);
		serve(9'h05C, 0, 7);
		// only source moves; continuous keeps the count at one
		chan(3'h5, 24'h000300, 24'h000400, 8'h01, 4'h9);
		node(8, 0, 1, 4'h6, 1, 3'h5);
		for (int i = 0; i < 3; i++) begin
			pulse(8);
			xfer(24'h000300 + i[23:0], 24'h000400, 0);
		end
		repeat (4) tick;
		chk({irq_o, node_ir_o[8]}, 2'b00);
		// nodes 44..47 stay disabled so their flags only collect
		ext_edge_i = 8'hE4;
		repeat (2) tick;
		ext_pin_i = 4'hF;
		repeat (8) tick;
		for (int k = 0; k < 4; k++)
			chk(node_ir_o[44 + k], k[0]);
		for (int k = 0; k < 4; k++)
			node(44 + k, 0, 0, 4'h0, 0, 0);
		ext_pin_i = 4'h0;
		repeat (8) tick;
		for (int k = 0; k < 4; k++)
			chk(node_ir_o[44 + k], k[1]);
		print_verdict;
	end
endmodule

bind iec_top iec_top_monitor iec_top_monitor_i (.clk_sys_i, .rst_n_i,
	.periph_req_i, .node_we_i, .cpu_level_i, .jump_cache_i, .irq_ack_i,
	.irq_o, .irq_vec_o, .irq_lvl_o, .irq_trap_o, .branch_o, .xfer_req_o,
	.node_ir_o, .busy_o);
